// ---- rtl/amc_pkg.sv ----
// constants shared by the clock output and alternate medium control registers
// assumes an 8-bit management bus on the device clock, 6-bit register address
//
// Contract
// - filter_view_enable at 1 connects the loop filter node to the view pin.
// - filter_view_enable resets to 0; at 0 the node stays disconnected.
// - alt_interface_enable at 1 enables the alternate medium interface, 0 disables.
// - alternate interface is disabled after reset; software enables it only when used.
// - alt_interface_enable never turns on the transmit clock outputs.
// - all four alternate pairs follow alt_interface_enable together.
package amc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [5:0] CLOCK_OUTPUT_CONTROL_OFS    = 6'h3b;
  localparam logic [5:0] ALT_MEDIUM_PORT_CONTROL_OFS = 6'h3c;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int         TX_CLOCK_OUT_ENABLE_BIT  = 3;
  localparam int         FILTER_VIEW_ENABLE_BIT   = 5;
  localparam int         ALT_INTERFACE_ENABLE_BIT = 3;
  localparam logic [7:0] CLOCK_OUTPUT_CONTROL_RST = 8'h00;
  localparam logic [7:0] ALT_MEDIUM_PORT_RST      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE      = 8'h00;
endpackage : amc_pkg

// ---- rtl/amc_byte_reg.sv ----
// one 8-bit read/write control register with a constant reset value
// assumes a single-cycle write strobe on the device clock
`timescale 1ns/1ps
module amc_byte_reg #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] q_r
);
  // every bit, reserved ones too, is held so reads give back what was written
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_r <= RST_VAL;
    end else if (wr_en) begin
      q_r <= wr_data;
    end
  end
endmodule : amc_byte_reg

// ---- rtl/amc_regs.sv ----
// clock output control and alternate medium control registers with pin enables
// assumes the management bus is driven by logic on ref_clk, one access per strobe
`timescale 1ns/1ps
module amc_regs (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       mgmt_sel,
  input  wire logic       mgmt_wr,
  input  wire logic [5:0] mgmt_addr,
  input  wire logic [7:0] mgmt_wdata,
  output logic      [7:0] mgmt_rdata,
  output logic            mgmt_ack,
  output logic            tx_clock_out_pair_oe,
  output logic            loop_filter_view_pin_connect,
  output logic            recovered_clock_out_pair_oe,
  output logic            recovered_data_out_pair_oe,
  output logic            alt_clock_in_pair_en,
  output logic            alt_data_in_pair_en
);
  // ****************************************
  // address decode
  // ****************************************
  logic       wr_clk_ctl;
  logic       wr_alt_ctl;
  logic [7:0] clock_output_control_r;
  logic [7:0] alt_medium_port_control_r;
  logic [7:0] rdata_nxt;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign wr_clk_ctl = mgmt_sel & mgmt_wr & hit(mgmt_addr, amc_pkg::CLOCK_OUTPUT_CONTROL_OFS);
  assign wr_alt_ctl = mgmt_sel & mgmt_wr & hit(mgmt_addr, amc_pkg::ALT_MEDIUM_PORT_CONTROL_OFS);

  // ****************************************
  // register storage
  // ****************************************
  amc_byte_reg #(
    .RST_VAL (amc_pkg::CLOCK_OUTPUT_CONTROL_RST)
  ) u_clock_output_control (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_clk_ctl),
    .wr_data (mgmt_wdata),
    .q_r     (clock_output_control_r)
  );

  amc_byte_reg #(
    .RST_VAL (amc_pkg::ALT_MEDIUM_PORT_RST)
  ) u_alt_medium_port_control (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_alt_ctl),
    .wr_data (mgmt_wdata),
    .q_r     (alt_medium_port_control_r)
  );

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    rdata_nxt = amc_pkg::UNMAPPED_READ_VALUE;
    if (hit(mgmt_addr, amc_pkg::CLOCK_OUTPUT_CONTROL_OFS)) begin
      rdata_nxt = clock_output_control_r;
    end else if (hit(mgmt_addr, amc_pkg::ALT_MEDIUM_PORT_CONTROL_OFS)) begin
      rdata_nxt = alt_medium_port_control_r;
    end
  end

  // read data holds until the next read so a slow master can sample it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mgmt_rdata <= 8'h00;
    end else if (mgmt_sel & ~mgmt_wr) begin
      mgmt_rdata <= rdata_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mgmt_ack <= 1'b0;
    end else begin
      mgmt_ack <= mgmt_sel;
    end
  end

  // ****************************************
  // pin enables
  // ****************************************
  // enables are reclocked so they change one cycle after the register, glitch free
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_clock_out_pair_oe         <= 1'b0;
      loop_filter_view_pin_connect <= 1'b0;
    end else begin
      // only the clock output register feeds this enable, never the alternate one
      tx_clock_out_pair_oe <=
        clock_output_control_r[amc_pkg::TX_CLOCK_OUT_ENABLE_BIT];
      loop_filter_view_pin_connect <=
        clock_output_control_r[amc_pkg::FILTER_VIEW_ENABLE_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      recovered_clock_out_pair_oe <= 1'b0;
      recovered_data_out_pair_oe  <= 1'b0;
      alt_clock_in_pair_en        <= 1'b0;
      alt_data_in_pair_en         <= 1'b0;
    end else begin
      recovered_clock_out_pair_oe <=
        alt_medium_port_control_r[amc_pkg::ALT_INTERFACE_ENABLE_BIT];
      recovered_data_out_pair_oe <=
        alt_medium_port_control_r[amc_pkg::ALT_INTERFACE_ENABLE_BIT];
      alt_clock_in_pair_en <=
        alt_medium_port_control_r[amc_pkg::ALT_INTERFACE_ENABLE_BIT];
      alt_data_in_pair_en <=
        alt_medium_port_control_r[amc_pkg::ALT_INTERFACE_ENABLE_BIT];
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_tx_clk_follows_write;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_clk_ctl ##1 ~wr_clk_ctl |=>
        tx_clock_out_pair_oe == $past(mgmt_wdata[amc_pkg::TX_CLOCK_OUT_ENABLE_BIT], 2);
  endproperty
  a_tx_clk_follows_write: assert property (p_tx_clk_follows_write)
    else $error("tx clock enable does not follow written bit");

  property p_tx_clk_reset_off;
    @(posedge ref_clk) $fell(sys_rst) |-> ~tx_clock_out_pair_oe;
  endproperty
  a_tx_clk_reset_off: assert property (p_tx_clk_reset_off)
    else $error("tx clock outputs on after reset");

  property p_filter_on;
    @(posedge ref_clk) disable iff (sys_rst)
      clock_output_control_r[amc_pkg::FILTER_VIEW_ENABLE_BIT] |=> loop_filter_view_pin_connect;
  endproperty
  a_filter_on: assert property (p_filter_on)
    else $error("filter view not connected while enabled");

  property p_filter_off;
    @(posedge ref_clk) disable iff (sys_rst)
      ~clock_output_control_r[amc_pkg::FILTER_VIEW_ENABLE_BIT] |=> ~loop_filter_view_pin_connect;
  endproperty
  a_filter_off: assert property (p_filter_off)
    else $error("filter view connected while disabled");

  property p_alt_follows_write;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_alt_ctl ##1 ~wr_alt_ctl |=>
        recovered_clock_out_pair_oe == $past(mgmt_wdata[amc_pkg::ALT_INTERFACE_ENABLE_BIT], 2);
  endproperty
  a_alt_follows_write: assert property (p_alt_follows_write)
    else $error("alternate enable does not follow written bit");

  property p_alt_reset_off;
    @(posedge ref_clk) $fell(sys_rst) |->
      ~alt_data_in_pair_en && ~alt_clock_in_pair_en &&
      ~recovered_clock_out_pair_oe && ~recovered_data_out_pair_oe;
  endproperty
  a_alt_reset_off: assert property (p_alt_reset_off)
    else $error("alternate interface on after reset");

  property p_alt_no_tx_clk;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_alt_ctl && ~wr_clk_ctl |=> ##1 $stable(tx_clock_out_pair_oe);
  endproperty
  a_alt_no_tx_clk: assert property (p_alt_no_tx_clk)
    else $error("alternate write changed tx clock enable");

  property p_alt_pairs_together;
    @(posedge ref_clk) disable iff (sys_rst)
      recovered_clock_out_pair_oe == recovered_data_out_pair_oe &&
      recovered_clock_out_pair_oe == alt_clock_in_pair_en &&
      recovered_clock_out_pair_oe == alt_data_in_pair_en;
  endproperty
  a_alt_pairs_together: assert property (p_alt_pairs_together)
    else $error("alternate pairs disagree");

  // write, one idle cycle, then a read of the same byte: the read sees the new value
  property p_readback;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_clk_ctl ##1 ~mgmt_sel ##1
        (mgmt_sel && ~mgmt_wr && hit(mgmt_addr, amc_pkg::CLOCK_OUTPUT_CONTROL_OFS))
        |=> mgmt_rdata == $past(mgmt_wdata, 3) && mgmt_ack;
  endproperty
  a_readback: assert property (p_readback)
    else $error("read does not return written byte");

  property p_tx_clk_off_when_clear;
    @(posedge ref_clk) disable iff (sys_rst)
      ~clock_output_control_r[amc_pkg::TX_CLOCK_OUT_ENABLE_BIT] |=> ~tx_clock_out_pair_oe;
  endproperty
  a_tx_clk_off_when_clear: assert property (p_tx_clk_off_when_clear)
    else $error("tx clock outputs driven while enable bit is clear");

  property p_alt_off_when_clear;
    @(posedge ref_clk) disable iff (sys_rst)
      ~alt_medium_port_control_r[amc_pkg::ALT_INTERFACE_ENABLE_BIT] |=>
        ~recovered_clock_out_pair_oe;
  endproperty
  a_alt_off_when_clear: assert property (p_alt_off_when_clear)
    else $error("alternate interface on while enable bit is clear");

  // ****************************************
  // management bus checks
  // ****************************************
  // every strobe cycle is one access, so ack mirrors the strobe one edge later
  property p_ack_follows_sel;
    @(posedge ref_clk) disable iff (sys_rst)
      mgmt_sel |=> mgmt_ack;
  endproperty
  a_ack_follows_sel: assert property (p_ack_follows_sel)
    else $error("access not acknowledged");

  property p_ack_single;
    @(posedge ref_clk) disable iff (sys_rst)
      ~mgmt_sel |=> ~mgmt_ack;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("ack without an access");

  property p_write_lands_clk;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_clk_ctl |=> clock_output_control_r == $past(mgmt_wdata);
  endproperty
  a_write_lands_clk: assert property (p_write_lands_clk)
    else $error("clock output control write lost");

  property p_write_lands_alt;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_alt_ctl |=> alt_medium_port_control_r == $past(mgmt_wdata);
  endproperty
  a_write_lands_alt: assert property (p_write_lands_alt)
    else $error("alternate medium control write lost");

  property p_read_alt_current;
    @(posedge ref_clk) disable iff (sys_rst)
      mgmt_sel && ~mgmt_wr && hit(mgmt_addr, amc_pkg::ALT_MEDIUM_PORT_CONTROL_OFS)
        |=> mgmt_rdata == $past(alt_medium_port_control_r) && mgmt_ack;
  endproperty
  a_read_alt_current: assert property (p_read_alt_current)
    else $error("alternate control read does not return held byte");

  // unmapped reads still answer, so a polling master never stalls
  property p_read_unmapped;
    @(posedge ref_clk) disable iff (sys_rst)
      mgmt_sel && ~mgmt_wr &&
      ~hit(mgmt_addr, amc_pkg::CLOCK_OUTPUT_CONTROL_OFS) &&
      ~hit(mgmt_addr, amc_pkg::ALT_MEDIUM_PORT_CONTROL_OFS)
        |=> mgmt_rdata == amc_pkg::UNMAPPED_READ_VALUE;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read returns nonzero data");

  property p_rdata_holds;
    @(posedge ref_clk) disable iff (sys_rst)
      ~(mgmt_sel && ~mgmt_wr) |=> $stable(mgmt_rdata);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds)
    else $error("read data changed without a read");
endmodule : amc_regs

// ---- verif/alt_medium_clock_control_regs_bench.sv ----
// testbench for the clock output and alternate medium control registers
// assumes amc_regs acks one cycle after each strobe and reclocks its pin enables once
`timescale 1ns/1ps
`define CHK(act, exp, msg) begin compares++; if ((act) !== (exp)) begin mismatches++; \
  $display("MISMATCH %0t %s", $time, msg); end end
module alt_medium_clock_control_regs_bench;
  logic       ref_clk    = 1'b0;
  logic       sys_rst    = 1'b1;
  logic       mgmt_sel   = 1'b0;
  logic       mgmt_wr    = 1'b0;
  logic [5:0] mgmt_addr  = 6'h00;
  logic [7:0] mgmt_wdata = 8'h00;
  logic [7:0] mgmt_rdata;
  logic       mgmt_ack;
  logic [5:0] pins;
  int         mismatches = 0;
  int         compares   = 0;

  always #5 ref_clk = ~ref_clk;

  amc_regs i_dut (
    .ref_clk                      (ref_clk),
    .sys_rst                      (sys_rst),
    .mgmt_sel                     (mgmt_sel),
    .mgmt_wr                      (mgmt_wr),
    .mgmt_addr                    (mgmt_addr),
    .mgmt_wdata                   (mgmt_wdata),
    .mgmt_rdata                   (mgmt_rdata),
    .mgmt_ack                     (mgmt_ack),
    .tx_clock_out_pair_oe         (pins[5]),
    .loop_filter_view_pin_connect (pins[4]),
    .recovered_clock_out_pair_oe  (pins[3]),
    .recovered_data_out_pair_oe   (pins[2]),
    .alt_clock_in_pair_en         (pins[1]),
    .alt_data_in_pair_en          (pins[0])
  );

  // ****************************************
  // bus access tasks, entered at a falling edge
  // ****************************************
  // strobe is dropped for a full cycle so back-to-back calls never rewrite it in one step
  task automatic access(input logic wr, input logic [5:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    mgmt_sel   = 1'b1;
    mgmt_wr    = wr;
    mgmt_addr  = addr;
    mgmt_wdata = wdata;
    @(negedge ref_clk);
    mgmt_sel = 1'b0;
    `CHK(mgmt_ack, 1'b1, "ack missing")
    rdata = mgmt_rdata;
    @(negedge ref_clk);
    `CHK(mgmt_ack, 1'b0, "ack longer than one cycle")
  endtask : access

  task automatic wr_reg(input logic [5:0] addr, input logic [7:0] data);
    logic [7:0] dummy;
    access(1'b1, addr, data, dummy);
  endtask : wr_reg

  task automatic rd_chk(input logic [5:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    access(1'b0, addr, 8'h00, v);
    `CHK(v, exp, "read data wrong")
  endtask : rd_chk

  // read-modify-write of one bit keeps every other held bit as found
  task automatic rmw(input logic [5:0] addr, input int pos, input logic val);
    logic [7:0] v;
    access(1'b0, addr, 8'h00, v);
    v[pos] = val;
    wr_reg(addr, v);
  endtask : rmw

  task automatic end_of_test;
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (3) @(negedge ref_clk);
    `CHK(pins, 6'h00, "pins on during reset")
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    rd_chk(amc_pkg::CLOCK_OUTPUT_CONTROL_OFS, 8'h00);
    rd_chk(amc_pkg::ALT_MEDIUM_PORT_CONTROL_OFS, 8'h00);
    rmw(amc_pkg::CLOCK_OUTPUT_CONTROL_OFS, 3, 1'b1);
    `CHK(pins, 6'h20, "tx clock enable")
    rmw(amc_pkg::CLOCK_OUTPUT_CONTROL_OFS, 5, 1'b1);
    `CHK(pins, 6'h30, "filter view enable")
    // only control bytes are written, never a loopback select, while the alternate pairs run
    rmw(amc_pkg::ALT_MEDIUM_PORT_CONTROL_OFS, 3, 1'b1);
    `CHK(pins, 6'h3f, "alt pairs enable")
    rmw(amc_pkg::CLOCK_OUTPUT_CONTROL_OFS, 3, 1'b0);
    `CHK(pins, 6'h1f, "alt on keeps tx clock off")
    rmw(amc_pkg::CLOCK_OUTPUT_CONTROL_OFS, 5, 1'b0);
    `CHK(pins, 6'h0f, "filter view disconnect")
    // every held bit reads back, reserved ones included
    wr_reg(amc_pkg::CLOCK_OUTPUT_CONTROL_OFS, 8'hf7);
    `CHK(pins, 6'h1f, "reserved bits leak into pins")
    wr_reg(amc_pkg::ALT_MEDIUM_PORT_CONTROL_OFS, 8'hf7);
    `CHK(pins, 6'h10, "alt pairs disable")
    rd_chk(amc_pkg::CLOCK_OUTPUT_CONTROL_OFS, 8'hf7);
    rd_chk(amc_pkg::ALT_MEDIUM_PORT_CONTROL_OFS, 8'hf7);
    wr_reg(6'h3d, 8'hff);
    rd_chk(6'h3d, amc_pkg::UNMAPPED_READ_VALUE);
    rd_chk(amc_pkg::CLOCK_OUTPUT_CONTROL_OFS, 8'hf7);
    // reset in mid-run with everything enabled
    wr_reg(amc_pkg::CLOCK_OUTPUT_CONTROL_OFS, 8'h28);
    wr_reg(amc_pkg::ALT_MEDIUM_PORT_CONTROL_OFS, 8'h08);
    `CHK(pins, 6'h3f, "all enabled before reset")
    sys_rst = 1'b1;
    @(negedge ref_clk);
    `CHK(pins, 6'h00, "pins survive reset")
    sys_rst = 1'b0;
    rd_chk(amc_pkg::CLOCK_OUTPUT_CONTROL_OFS, amc_pkg::CLOCK_OUTPUT_CONTROL_RST);
    rd_chk(amc_pkg::ALT_MEDIUM_PORT_CONTROL_OFS, amc_pkg::ALT_MEDIUM_PORT_RST);
    end_of_test();
  end

  // the sequence needs well under 200 cycles
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
endmodule : alt_medium_clock_control_regs_bench
